// ### lut_regs_defines.svh
// Register offsets, field positions and reset values of the lookup status and aging registers
`ifndef LUT_REGS_DEFINES_SVH
`define LUT_REGS_DEFINES_SVH

// Printed offsets are not all multiples of four: each is a word index
`define IDX_AGE_PERIOD 12'h0313
`define IDX_EVENT_STATUS 12'h0314
`define IDX_EVENT_MASK 12'h0315
`define IDX_AF_WF_INDEX 12'h0316
`define IDX_LEARN_FAIL_INDEX 12'h0318
`define IDX_HOST_ACCESS_INDEX 12'h031a
`define IDX_UNK_UC_CTRL 12'h0320
// Index field within the byte address
`define ADDR_IDX_HI 13
`define ADDR_IDX_LO 2

// Reset values
`define AGE_PERIOD_RESET 8'h4b
`define EVENT_MASK_RESET 3'h7

// Event bit positions
`define EV_WRITE_FAIL 0
`define EV_ALMOST_FULL 1
`define EV_LEARN_FAIL 2
`define EV_COUNT 3

// Unknown-unicast control fields
`define UC_FWD_EN_BIT 31
`define UC_PORTS_HI 2

// Index widths
`define ENTRY_IDX_W 12
`define BUCKET_IDX_W 10

// AHB transfer type
`define HTRANS_NONSEQ 2'h2

// One-second tick at 100 MHz
`define ONE_SECOND_CYCLES 27'h5f5_e100

`endif

// ### lut_regs_pkg.sv
// Types shared by the lookup status and aging register block
`default_nettype none
package lut_regs_pkg;
    // Unknown-packet category after priority
    typedef enum logic [1:0] {
        CAT_NONE,
        CAT_UNK_VID,
        CAT_UNK_UC,
        CAT_UNK_MC
    } unknown_cat_e;
endpackage : lut_regs_pkg
`default_nettype wire

// ### lookup_table_status_aging_regs.sv
// AHB-Lite register block for lookup aging, lookup events and unknown-unicast forwarding
// Overview of the block
// The block sits between host software and the lookup engine.
// Software reaches it over a single AHB-Lite slave port.
// The lookup engine reports its events as one-cycle pulses.
// Each pulse comes with the index that goes with it.
// The block keeps sticky status, a mask and the captured indices.
// It also keeps the aging period and the unicast forward control.
//
// Register map
// Each register takes one aligned word of the bus.
// The byte address is four times the register's word index.
// Data sits in the low bits of the word; the unicast forward enable is bit 31.
// Reserved bits read as zero, and writes to them are dropped.
// Unmapped words read as zero, and writes to them are dropped.
// Transfer size is not decoded: every access is a whole word.
//
// Bus timing
// The slave never inserts wait states once reset has lifted.
// The address phase is latched at the edge that takes it.
// Write data is applied at the edge that ends the data phase.
// Read data is registered at the end of the address phase.
// It then stands for the whole data phase.
// Limitation: a read right behind a write to the same word
// in a back-to-back transfer returns the old value.
// Software that needs the new value must leave one idle cycle.
// The response is always OKAY, so no error path exists.
//
// Event handling
// A status bit is set on the edge that samples its pulse.
// A write of one clears a status bit; a zero leaves it alone.
// When a pulse and a clear meet in one cycle, the pulse wins.
// This trades a lost clear for never losing an event.
// The summary flag and interrupt lag status by one edge.
// Both come straight from flip-flops, so they never glitch.
// Masks reset to all ones, so nothing interrupts at start-up.
//
// Captured indices
// Almost-full and write-fail share one capture field.
// Write fail wins if both fire in the same cycle.
// The upper bits of a write-fail capture read as zero.
// Learn-fail and host-access captures have their own fields.
// Every capture simply follows the latest event of its kind.
//
// Aging
// A free-running prescaler gives a one-second tick.
// The tick count is a fixed constant for a 100 MHz clock.
// A faster or slower clock would need that constant changed.
// The aging time of an entry is period times its age count.
// It is worked out one cycle after the table walker asks.
//
// Unknown packet handling
// Categories are ranked: unknown VID, unicast, then multicast.
// Only the top-ranked category of a packet is reported.
// Only unicast forwarding is decided in this block.
// The port select is zero while forwarding is disabled.
//
// Reset
// The external reset is asynchronous and active low.
// It is released through two flip-flops before use.
// Only the second flip-flop reads the first.
// The slave shows not-ready until the first edge after the internal reset lifts.
`timescale 1ns/10ps
`default_nettype none
`include "lut_regs_defines.svh"

module lookup_table_status_aging_regs
    import lut_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Lookup engine events
    input wire logic learn_fail_evt,
    input wire logic almost_full_evt,
    input wire logic write_fail_evt,
    input wire logic [11:0] event_entry_index,
    input wire logic [9:0] event_bucket_index,
    input wire logic host_access_evt,
    input wire logic [9:0] host_access_bucket,
    // Aging request from the table walker
    input wire logic age_entry_req,
    input wire logic [7:0] age_entry_count,
    // Unknown packet classification
    input wire logic pkt_valid,
    input wire logic pkt_unknown_vid,
    input wire logic pkt_unknown_uc,
    input wire logic pkt_unknown_mc,
    // Outputs to switch fabric
    output logic age_tick,
    output logic [15:0] age_limit_sec,
    output logic [7:0] age_period_out,
    output logic lookup_engine_summary_flag,
    output logic lookup_irq,
    output logic [1:0] pkt_category,
    output logic uc_forward_valid,
    output logic [2:0] uc_forward_ports
);

    // Reset synchroniser; first stage read only by the second
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Register storage
    logic [7:0] age_period; // Aging period in seconds
    logic [`EV_COUNT-1:0] event_status; // Sticky events
    logic [`EV_COUNT-1:0] event_mask; // One disables
    logic [`ENTRY_IDX_W-1:0] af_wf_index; // Shared capture field
    logic [`BUCKET_IDX_W-1:0] learn_fail_index;
    logic [`BUCKET_IDX_W-1:0] host_access_index;
    logic uc_fwd_en;
    logic [`UC_PORTS_HI:0] uc_ports;

    // Latched address phase
    logic wr_pend;
    logic rd_pend;
    logic [11:0] ph_idx;

    // Word index from a byte address
    function automatic logic [11:0] addr_index(input logic [31:0] a);
        addr_index = a[`ADDR_IDX_HI:`ADDR_IDX_LO];
    endfunction : addr_index

    // Decode a write to one index; used by every writable register
    function automatic logic hit(input logic [11:0] idx, input logic [11:0] want);
        hit = (idx == want);
    endfunction : hit

    logic ahb_take;
    assign ahb_take = hsel && hready && (htrans == `HTRANS_NONSEQ);

    // Address phase capture; zero wait states
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ph_idx <= 12'h000;
        end else begin
            wr_pend <= ahb_take && hwrite;
            rd_pend <= ahb_take && !hwrite;
            ph_idx <= ahb_take ? addr_index(haddr) : ph_idx;
        end
    end

    // Ready from the first edge after reset, always OKAY
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read mux for the address-phase index; unmapped reads zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (addr_index(haddr))
            `IDX_AGE_PERIOD: next_rdata[7:0] = age_period;
            `IDX_EVENT_STATUS: next_rdata[`EV_COUNT-1:0] = event_status;
            `IDX_EVENT_MASK: next_rdata[`EV_COUNT-1:0] = event_mask;
            `IDX_AF_WF_INDEX: next_rdata[`ENTRY_IDX_W-1:0] = af_wf_index;
            `IDX_LEARN_FAIL_INDEX: next_rdata[`BUCKET_IDX_W-1:0] = learn_fail_index;
            `IDX_HOST_ACCESS_INDEX: next_rdata[`BUCKET_IDX_W-1:0] = host_access_index;
            `IDX_UNK_UC_CTRL: begin
                next_rdata[`UC_FWD_EN_BIT] = uc_fwd_en;
                next_rdata[`UC_PORTS_HI:0] = uc_ports;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at end of address phase, stands during data phase
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Age period register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            age_period <= `AGE_PERIOD_RESET;
        end else if (wr_pend && hit(ph_idx, `IDX_AGE_PERIOD)) begin
            age_period <= hwdata[7:0];
        end
    end

    // Event inputs gathered by bit position
    logic [`EV_COUNT-1:0] event_in;
    always_comb begin
        event_in = '0;
        event_in[`EV_LEARN_FAIL] = learn_fail_evt;
        event_in[`EV_ALMOST_FULL] = almost_full_evt;
        event_in[`EV_WRITE_FAIL] = write_fail_evt;
    end

    // Sticky status bits; an event in the clearing cycle wins
    genvar g;
    generate
        for (g = 0; g < `EV_COUNT; g = g + 1) begin : g_status
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    event_status[g] <= 1'b0;
                end else if (event_in[g]) begin
                    event_status[g] <= 1'b1;
                end else if (wr_pend && hit(ph_idx, `IDX_EVENT_STATUS) && hwdata[g]) begin
                    event_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask register
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            event_mask <= `EVENT_MASK_RESET;
        end else if (wr_pend && hit(ph_idx, `IDX_EVENT_MASK)) begin
            event_mask <= hwdata[`EV_COUNT-1:0];
        end
    end

    // Summary flag and interrupt, registered from status and mask
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lookup_engine_summary_flag <= 1'b0;
            lookup_irq <= 1'b0;
        end else begin
            lookup_engine_summary_flag <= |event_status;
            lookup_irq <= |(event_status & ~event_mask);
        end
    end

    // Shared capture field; write fail wins if both fire together
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            af_wf_index <= '0;
        end else if (write_fail_evt) begin
            af_wf_index <= {2'b00, event_bucket_index};
        end else if (almost_full_evt) begin
            af_wf_index <= event_entry_index;
        end
    end

    // Learn fail bucket capture
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            learn_fail_index <= '0;
        end else if (learn_fail_evt) begin
            learn_fail_index <= event_bucket_index;
        end
    end

    // Host access bucket capture
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            host_access_index <= '0;
        end else if (host_access_evt) begin
            host_access_index <= host_access_bucket;
        end
    end

    // Unknown-unicast control; reserved bits ignored
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            uc_fwd_en <= 1'b0;
            uc_ports <= '0;
        end else if (wr_pend && hit(ph_idx, `IDX_UNK_UC_CTRL)) begin
            uc_fwd_en <= hwdata[`UC_FWD_EN_BIT];
            uc_ports <= hwdata[`UC_PORTS_HI:0];
        end
    end

    // One-second prescaler for aging
    logic [26:0] sec_cnt;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sec_cnt <= '0;
            age_tick <= 1'b0;
        end else if (sec_cnt == `ONE_SECOND_CYCLES - 27'd1) begin
            sec_cnt <= '0;
            age_tick <= 1'b1;
        end else begin
            sec_cnt <= sec_cnt + 27'd1;
            age_tick <= 1'b0;
        end
    end

    // Aging time of an entry: period times its age count, in seconds
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            age_limit_sec <= '0;
            age_period_out <= `AGE_PERIOD_RESET;
        end else begin
            age_period_out <= age_period;
            if (age_entry_req) begin
                age_limit_sec <= 16'(age_period) * 16'(age_entry_count);
            end
        end
    end

    // Classify unknown packets by priority
    unknown_cat_e next_cat;
    always_comb begin
        if (pkt_unknown_vid) begin
            next_cat = CAT_UNK_VID;
        end else if (pkt_unknown_uc) begin
            next_cat = CAT_UNK_UC;
        end else if (pkt_unknown_mc) begin
            next_cat = CAT_UNK_MC;
        end else begin
            next_cat = CAT_NONE;
        end
    end

    // Forwarding decision; only unicast handled here
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pkt_category <= CAT_NONE;
            uc_forward_valid <= 1'b0;
            uc_forward_ports <= '0;
        end else begin
            pkt_category <= pkt_valid ? next_cat : CAT_NONE;
            uc_forward_valid <= pkt_valid && (next_cat == CAT_UNK_UC) && uc_fwd_en;
            uc_forward_ports <= uc_fwd_en ? uc_ports : '0;
        end
    end

endmodule : lookup_table_status_aging_regs
`default_nettype wire

// ### lut_regs_checker_assertions.sv
// Port-level assertions for the lookup status and aging register block
`timescale 1ns/10ps
`default_nettype none
module lut_regs_checker
    import lut_regs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hreadyout,
    input wire logic learn_fail_evt,
    input wire logic almost_full_evt,
    input wire logic write_fail_evt,
    input wire logic age_entry_req,
    input wire logic [7:0] age_entry_count,
    input wire logic [15:0] age_limit_sec,
    input wire logic [7:0] age_period_out,
    input wire logic lookup_engine_summary_flag,
    input wire logic lookup_irq,
    input wire logic pkt_valid,
    input wire logic pkt_unknown_vid,
    input wire logic pkt_unknown_uc,
    input wire logic [1:0] pkt_category,
    input wire logic uc_forward_valid
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Status lands one edge after the pulse, summary one edge later
    sequence s_flag_up;
        ##2 lookup_engine_summary_flag;
    endsequence

    AST_LEARN_FAIL: assert property (learn_fail_evt |-> s_flag_up)
        else $error("learn fail did not raise the summary flag");
    AST_ALMOST_FULL: assert property (almost_full_evt |-> s_flag_up)
        else $error("almost full did not raise the summary flag");
    AST_WRITE_FAIL: assert property (write_fail_evt |-> s_flag_up)
        else $error("write fail did not raise the summary flag");
    AST_IRQ_SUMMARY: assert property (lookup_irq |-> lookup_engine_summary_flag)
        else $error("interrupt high with no status bit set");
    AST_AGE_LIMIT: assert property (age_entry_req |=> age_limit_sec ==
        {8'h00, age_period_out} * {8'h00, $past(age_entry_count)})
        else $error("age limit is not period times count");
    AST_CAT_VID: assert property (pkt_valid && pkt_unknown_vid |=>
        pkt_category == CAT_UNK_VID) else $error("unknown VID lost priority");
    AST_CAT_UC: assert property (pkt_valid && !pkt_unknown_vid && pkt_unknown_uc |=>
        pkt_category == CAT_UNK_UC) else $error("unknown unicast misclassified");
    AST_UC_FWD: assert property (uc_forward_valid |->
        pkt_category == CAT_UNK_UC && $past(pkt_valid)) else $error("stray unicast forward");
    // Zero-wait slave: once ready, ready stays
    AST_READY_HOLD: assert property ($past(hreadyout) |-> hreadyout)
        else $error("hreadyout dropped");
endmodule : lut_regs_checker

bind lookup_table_status_aging_regs lut_regs_checker lut_regs_checker_i (.clk_sys, .rst_n,
    .hreadyout, .learn_fail_evt, .almost_full_evt, .write_fail_evt, .age_entry_req,
    .age_entry_count, .age_limit_sec, .age_period_out, .lookup_engine_summary_flag,
    .lookup_irq, .pkt_valid, .pkt_unknown_vid, .pkt_unknown_uc, .pkt_category,
    .uc_forward_valid);
`default_nettype wire

// ### lookup_table_status_aging_regs_tb_top.sv
// Self-checking bench for the lookup status and aging register block
`timescale 1ns/10ps
`default_nettype none
`include "lut_regs_defines.svh"
module lookup_table_status_aging_regs_tb_top
    import lut_regs_pkg::*;
;
    // Stimulus, all valued at time zero
    logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic learn_fail_evt = 1'b0, almost_full_evt = 1'b0, write_fail_evt = 1'b0;
    logic host_access_evt = 1'b0, age_entry_req = 1'b0, pkt_valid = 1'b0;
    logic pkt_unknown_vid = 1'b0, pkt_unknown_uc = 1'b0, pkt_unknown_mc = 1'b0;
    logic [11:0] event_entry_index = 12'h000;
    logic [9:0] event_bucket_index = 10'h000, host_access_bucket = 10'h000;
    logic [7:0] age_entry_count = 8'h00;
    // Observed outputs
    logic hreadyout, hresp, age_tick, lookup_engine_summary_flag, lookup_irq, uc_forward_valid;
    logic [31:0] hrdata;
    logic [15:0] age_limit_sec;
    logic [7:0] age_period_out;
    logic [1:0] pkt_category;
    logic [2:0] uc_forward_ports;
    unknown_cat_e cat;
    int failures = 0, n_tests = 0, cycles = 0;
    // Register rows: index, write data, read-back value
    typedef struct {logic [11:0] idx; logic [31:0] wd; logic [31:0] exp;} row_s;
    row_s rows [8] = '{'{`IDX_AGE_PERIOD, 32'hFFFF_FF5A, 32'h0000_005A},
        '{`IDX_EVENT_MASK, 32'h0000_00FA, 32'h0000_0002},
        '{`IDX_UNK_UC_CTRL, 32'hFFFF_FFFF, 32'h8000_0007},
        '{`IDX_EVENT_STATUS, 32'h0000_00FF, 32'h0000_0000},
        '{`IDX_LEARN_FAIL_INDEX, 32'h0000_FFFF, 32'h0000_0000},
        '{`IDX_AF_WF_INDEX, 32'h0000_FFFF, 32'h0000_0000},
        '{`IDX_HOST_ACCESS_INDEX, 32'h0000_FFFF, 32'h0000_0000},
        '{12'h0321, 32'h0000_FFFF, 32'h0000_0000}};

    // Bus ready loops back, as with a single slave
    lookup_table_status_aging_regs lookup_table_status_aging_regs_i (.clk_sys, .rst_n, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .learn_fail_evt, .almost_full_evt, .write_fail_evt, .event_entry_index,
        .event_bucket_index, .host_access_evt, .host_access_bucket, .age_entry_req,
        .age_entry_count, .pkt_valid, .pkt_unknown_vid, .pkt_unknown_uc, .pkt_unknown_mc,
        .age_tick, .age_limit_sec, .age_period_out, .lookup_engine_summary_flag, .lookup_irq,
        .pkt_category, .uc_forward_valid, .uc_forward_ports);

    always #5 clk_sys = ~clk_sys;

    // Hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One single transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {18'h0_0000, idx, 2'b00};
        hwrite <= wr;
        htrans <= `HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask : rdchk

    // Event pulse, one cycle, then time for status and interrupt to settle
    task automatic evt(input logic [3:0] ev, input logic [11:0] ent, input logic [9:0] bkt);
        {host_access_evt, learn_fail_evt, almost_full_evt, write_fail_evt} <= ev;
        event_entry_index <= ent;
        event_bucket_index <= bkt;
        host_access_bucket <= bkt;
        @(posedge clk_sys);
        {host_access_evt, learn_fail_evt, almost_full_evt, write_fail_evt} <= 4'h0;
        repeat (3) @(posedge clk_sys);
    endtask : evt

    task automatic age(input logic [7:0] cnt, input logic [15:0] exp);
        age_entry_count <= cnt;
        age_entry_req <= 1'b1;
        @(posedge clk_sys);
        age_entry_req <= 1'b0;
        @(posedge clk_sys);
        chk({16'h0000, age_limit_sec}, {16'h0000, exp});
    endtask : age

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Access kinds, reserved bits and an unmapped word
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].idx, rows[i].wd);
            rdchk(rows[i].idx, rows[i].exp);
        end
        // Mask is now 2: learn and write fail enabled, almost full masked
        evt(4'h4, 12'h000, 10'h2A5);
        rdchk(`IDX_EVENT_STATUS, 32'h0000_0004);
        rdchk(`IDX_LEARN_FAIL_INDEX, 32'h0000_02A5);
        chk({31'h0, lookup_irq}, 32'h0000_0001);
        ahb(1'b1, `IDX_EVENT_STATUS, 32'h0000_0003);
        rdchk(`IDX_EVENT_STATUS, 32'h0000_0004);
        ahb(1'b1, `IDX_EVENT_STATUS, 32'h0000_0004);
        rdchk(`IDX_EVENT_STATUS, 32'h0000_0000);
        chk({31'h0, lookup_irq}, 32'h0000_0000);
        evt(4'h2, 12'hABC, 10'h000);
        rdchk(`IDX_AF_WF_INDEX, 32'h0000_0ABC);
        chk({30'h0, lookup_irq, lookup_engine_summary_flag}, 32'h0000_0001);
        evt(4'h1, 12'h000, 10'h155);
        rdchk(`IDX_AF_WF_INDEX, 32'h0000_0155);
        rdchk(`IDX_EVENT_STATUS, 32'h0000_0003);
        evt(4'h8, 12'h000, 10'h3C3);
        rdchk(`IDX_HOST_ACCESS_INDEX, 32'h0000_03C3);
        ahb(1'b1, `IDX_EVENT_MASK, 32'h0000_0007);
        repeat (2) @(posedge clk_sys);
        chk({30'h0, lookup_irq, lookup_engine_summary_flag}, 32'h0000_0001);
        // Mid-run reset brings back defaults
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({24'h0, age_period_out}, 32'h0000_004B);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdchk(`IDX_AGE_PERIOD, 32'h0000_004B);
        rdchk(`IDX_EVENT_MASK, 32'h0000_0007);
        rdchk(`IDX_UNK_UC_CTRL, 32'h0000_0000);
        age(8'h03, 16'h00E1);
        ahb(1'b1, `IDX_AGE_PERIOD, 32'h0000_00FF);
        age(8'hFF, 16'hFE01);
        // Every mix of unknown categories, forwarding on to ports 2 and 0, then unicast with forwarding off
        ahb(1'b1, `IDX_UNK_UC_CTRL, 32'h8000_0005);
        for (int k = 0; k < 9; k++) begin
            if (k == 8) ahb(1'b1, `IDX_UNK_UC_CTRL, 32'h0000_0005);
            {pkt_unknown_vid, pkt_unknown_uc, pkt_unknown_mc} <= (k == 8) ? 3'h2 : k[2:0];
            pkt_valid <= 1'b1;
            repeat (2) @(posedge clk_sys);
            cat = (k == 8) ? CAT_UNK_UC : k[2] ? CAT_UNK_VID : k[1] ? CAT_UNK_UC : k[0] ?
                CAT_UNK_MC : CAT_NONE;
            chk({30'h0, pkt_category}, {30'h0, cat});
            chk({31'h0, uc_forward_valid}, {31'h0, cat == CAT_UNK_UC && k < 8});
            chk({29'h0, uc_forward_ports}, (k == 8) ? 32'h0000_0000 : 32'h0000_0005);
            pkt_valid <= 1'b0;
            @(posedge clk_sys);
        end
        test_done();
    end
endmodule : lookup_table_status_aging_regs_tb_top
`default_nettype wire
